// ---- inc/pmoc_defines.svh ----
`ifndef PMOC_DEFINES_SVH
`define PMOC_DEFINES_SVH

// Core clock rate and hardware reset deglitch time.
`define PMOC_CLK_HZ 50000000
`define PMOC_DEGLITCH_MS 5
`define PMOC_DEGLITCH_CYCLES (`PMOC_DEGLITCH_MS * (`PMOC_CLK_HZ / 1000))

// Register offsets.
`define PMOC_ADDR_SUPPLY_GOOD 8'h02
`define PMOC_ADDR_FAULT_MASK 8'h07
`define PMOC_ADDR_MODE_CONTROL 8'h08

// Mode control field positions.
`define PMOC_BIT_SOFT_RESET 0
`define PMOC_BIT_DEFAULTS_N 1
`define PMOC_BIT_BOOST_OSC 3
`define PMOC_BIT_SOFT_SLEEP 6
`define PMOC_BIT_STANDBY 7

// Reset values and writable bits.
`define PMOC_MODE_RESET 8'h00
`define PMOC_MODE_WRITABLE 8'hCB
`define PMOC_MASK_RESET 8'hFF

`endif

// ---- inc/pmoc_pkg.sv ----
package pmoc_pkg;

    typedef enum logic [2:0] {
        PMOC_NO_POWER = 3'h0,
        PMOC_ENABLE = 3'h1,
        PMOC_SEQUENCING = 3'h2,
        PMOC_RESET = 3'h3,
        PMOC_SUPPLY_GOOD_STATUS_CHECK = 3'h4,
        PMOC_NORMAL = 3'h5,
        PMOC_SLEEP = 3'h6
    } pmoc_state_t;

endpackage

// ---- hw/pmoc_mode_control.sv ----
// Summary of operation
// (R1) Supply fault mask bits power up masked.
// (R2) Masked supplies raise no fault; status still shows out of regulation.
// (R3) Supply-good check without unmasked fault enters NORMAL.
// (R4) In NORMAL, thermal or low system voltage fault enters SLEEP.
// (R5) In NORMAL, unmasked supply-good fault enters NO POWER.
// (R6) In NORMAL, writing soft reset bit B0 enters RESET.
// (R7) In NORMAL, writing soft sleep bit B6 enters SLEEP.
// (R8) Soft reset and soft sleep bits clear themselves after use.
// (R9) SLEEP entry drives host reset low and restores some register groups.
// (R10) In SLEEP sequencing is off and all supplies except backup are off.
// (R11) In SLEEP the backup regulator follows its enable bit.
// (R12) Leaving SLEEP, supplies come up from restored defaults.
// (R13) Thermal SLEEP ends only through undervoltage into NO POWER.
// (R14) Battery-only SLEEP exits to ENABLE on input power, else NO POWER.
// (R15) With both sources, input removal then reconnection exits to ENABLE.
// (R16) Standby request sets both bucks to standby voltage and PFM.
// (R17) Hardware reset low beyond 5 ms deglitch drives host reset low.
// (R18) RESET starts on the rising edge of the hardware reset input.
// (R19) Hardware and software resets leave registers unchanged.
// (R20) Host sets defaults-loaded flag; device clears it on default reload. Here SLEEP entry by B6 or thermal/low voltage fault leaves it set.
// (R21) Toggle of an unmasked supply-good bit is a supply fault event.
// (R22) Supply-good check with unmasked fault enters SLEEP.
// (R23) RESET ends on reset timer expiry into supply-good check.
// (R24) Hardware reset input is synchronised; deglitch restarts when high.
// (R25) Faults take precedence over host reset, sleep and standby requests.
`timescale 1ns/10ps
`include "pmoc_defines.svh"

////////////////////////////////////////////////////////////////////////////
module pmoc_sync #(
    parameter int W = 1
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta;

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            meta <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta <= async_in;
            sync_out <= meta;
        end
    end
endmodule

////////////////////////////////////////////////////////////////////////////
module pmoc_mode_control
    import pmoc_pkg::*;
#(
    parameter int DEGLITCH_CYCLES = `PMOC_DEGLITCH_CYCLES
) (
    // Clock and power-on reset.
    input wire logic core_clk,
    input wire logic rst_n,
    // Register port from the serial host interface.
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Asynchronous status inputs.
    input wire logic hw_reset_input,
    input wire logic thermal_fault,
    input wire logic system_voltage_low,
    input wire logic uvlo_detect,
    input wire logic battery_present,
    input wire logic input_power_present,
    input wire logic standby_gpio,
    input wire logic reset_timer_expired,
    input wire logic sequence_done,
    input wire logic [7:0] supply_good_status,
    // Backup regulator enable bit from the regulator enable register.
    input wire logic backup_clock_en,
    // Mode outputs.
    output logic host_reset_output,
    output logic sequencing_enable,
    output logic supplies_on,
    output logic backup_clock_regulator_on,
    output logic restore_defaults,
    output logic buck_a_standby,
    output logic buck_b_standby,
    output logic buck_pfm,
    output logic boost_low_freq_osc,
    output pmoc_state_t mode_state
);
    logic [17:0] deglitch_max;
    assign deglitch_max = 18'(DEGLITCH_CYCLES);

    ////////////////////////////////////////////////////////////////////////
    // Synchronisers.
    logic [8:0] pins_s;
    logic [7:0] sts_s;
    logic [7:0] sts_q;

    pmoc_sync #(.W(9)) u_sync_pins (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .async_in({hw_reset_input, thermal_fault, system_voltage_low,
                   uvlo_detect, battery_present, input_power_present,
                   standby_gpio, reset_timer_expired, sequence_done}),
        .sync_out(pins_s)
    ); // R24

    pmoc_sync #(.W(8)) u_sync_status (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .async_in(supply_good_status),
        .sync_out(sts_s)
    );

    wire hw_s = pins_s[8];
    wire thermal_s = pins_s[7];
    wire lowsys_s = pins_s[6];
    wire uvlo_s = pins_s[5];
    wire input_s = pins_s[3];
    wire standby_gpio_s = pins_s[2];
    wire timer_s = pins_s[1];
    wire seq_done_s = pins_s[0];

    ////////////////////////////////////////////////////////////////////////
    // Registers and decode.
    logic [7:0] mode_ctl;
    logic [7:0] fault_mask;
    logic [7:0] next_mode_ctl;
    logic [7:0] next_fault_mask;
    pmoc_state_t state;
    pmoc_state_t next_state;

    // Register writes are held off while the host is in reset; reads are not.
    wire wr_ok = reg_wr && host_reset_output;
    wire wr_mode = wr_ok && (reg_addr == `PMOC_ADDR_MODE_CONTROL);
    wire wr_mask = wr_ok && (reg_addr == `PMOC_ADDR_FAULT_MASK);
    wire [7:0] rd_mux = (reg_addr == `PMOC_ADDR_MODE_CONTROL) ? mode_ctl :
        (reg_addr == `PMOC_ADDR_FAULT_MASK) ? fault_mask :
        (reg_addr == `PMOC_ADDR_SUPPLY_GOOD) ? sts_s : 8'h00;

    wire [7:0] unmasked_level = sts_s & ~fault_mask; // R2
    wire [7:0] unmasked_toggle = (sts_s ^ sts_q) & ~fault_mask; // R21
    wire pg_level = |unmasked_level;
    wire pg_event = pg_level || (|unmasked_toggle); // R21
    wire env_fault = thermal_s || lowsys_s;
    wire soft_rst = mode_ctl[`PMOC_BIT_SOFT_RESET];
    wire soft_sleep = mode_ctl[`PMOC_BIT_SOFT_SLEEP];

    ////////////////////////////////////////////////////////////////////////
    // Hardware reset deglitch.
    logic [17:0] deglitch_cnt;
    logic hw_q;
    logic hw_armed;
    wire hw_long = (deglitch_cnt == deglitch_max);
    wire hw_rise = hw_s && !hw_q;
    wire hw_reset_go = hw_rise && hw_armed; // R18

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            deglitch_cnt <= 18'h00000;
            hw_q <= 1'b1;
            hw_armed <= 1'b0;
        end
        else
        begin
            hw_q <= hw_s;
            if (hw_s)
                deglitch_cnt <= 18'h00000; // R24
            else if (!hw_long)
                deglitch_cnt <= deglitch_cnt + 18'h00001;
            // The rise must disarm even though the count still shows full.
            if (hw_rise)
                hw_armed <= 1'b0; // R18
            else if (hw_long)
                hw_armed <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Mode state machine.
    logic sleep_thermal;
    logic input_gone;
    wire sleep_exit_input = input_s && input_gone; // R14 R15

    always_comb
    begin
        next_state = state;
        if (uvlo_s)
            next_state = PMOC_NO_POWER; // R13 R14
        else
        begin
            case (state)
                PMOC_NO_POWER:
                    next_state = PMOC_ENABLE;
                PMOC_ENABLE:
                    if (!lowsys_s)
                        next_state = PMOC_SEQUENCING;
                PMOC_SEQUENCING:
                    if (seq_done_s)
                        next_state = PMOC_RESET;
                PMOC_RESET:
                    if (timer_s)
                        next_state = PMOC_SUPPLY_GOOD_STATUS_CHECK; // R23
                PMOC_SUPPLY_GOOD_STATUS_CHECK:
                    if (pg_level)
                        next_state = PMOC_SLEEP; // R22
                    else
                        next_state = PMOC_NORMAL; // R3
                PMOC_NORMAL:
                    if (env_fault)
                        next_state = PMOC_SLEEP; // R4 R25
                    else if (pg_event)
                        next_state = PMOC_NO_POWER; // R5 R25
                    else if (hw_reset_go || soft_rst)
                        next_state = PMOC_RESET; // R6 R18
                    else if (soft_sleep)
                        next_state = PMOC_SLEEP; // R7
                PMOC_SLEEP:
                    if (!sleep_thermal && sleep_exit_input)
                        next_state = PMOC_ENABLE; // R13 R14 R15
                default:
                    next_state = PMOC_NO_POWER;
            endcase
        end
    end

    wire entering_sleep = (next_state == PMOC_SLEEP) && (state != PMOC_SLEEP);
    wire entering_nopwr = (next_state == PMOC_NO_POWER) &&
        (state != PMOC_NO_POWER);
    wire pg_reload = (state == PMOC_SUPPLY_GOOD_STATUS_CHECK && pg_level) ||
        (state == PMOC_NORMAL && pg_event && !env_fault);

    // Registers keep their values across hardware and software resets.
    always_comb
    begin
        next_mode_ctl = mode_ctl;
        next_fault_mask = fault_mask;
        if (entering_nopwr)
        begin
            next_mode_ctl = `PMOC_MODE_RESET; // R20
            next_fault_mask = `PMOC_MASK_RESET; // R1
        end
        else
        begin
            next_mode_ctl[`PMOC_BIT_SOFT_RESET] = 1'b0; // R8
            next_mode_ctl[`PMOC_BIT_SOFT_SLEEP] = 1'b0; // R8
            if (wr_mode)
                next_mode_ctl = reg_wdata & `PMOC_MODE_WRITABLE; // R19
            if (pg_reload)
                next_mode_ctl[`PMOC_BIT_DEFAULTS_N] = 1'b0; // R20
            if (wr_mask)
                next_fault_mask = reg_wdata;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            state <= PMOC_NO_POWER;
            mode_ctl <= `PMOC_MODE_RESET;
            fault_mask <= `PMOC_MASK_RESET; // R1
            sts_q <= 8'h00;
            reg_rdata <= 8'h00;
            sleep_thermal <= 1'b0;
            input_gone <= 1'b0;
        end
        else
        begin
            state <= next_state;
            mode_ctl <= next_mode_ctl;
            fault_mask <= next_fault_mask;
            sts_q <= sts_s;
            if (reg_rd)
                reg_rdata <= rd_mux;
            if (entering_sleep)
            begin
                sleep_thermal <= (state == PMOC_NORMAL) && thermal_s; // R13
                input_gone <= !input_s; // R14
            end
            else if (!input_s)
                input_gone <= 1'b1; // R15
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs, registered from the next state so they align with it.
    wire next_on = (next_state == PMOC_SEQUENCING) ||
        (next_state == PMOC_RESET) || (next_state == PMOC_SUPPLY_GOOD_STATUS_CHECK) ||
        (next_state == PMOC_NORMAL);
    wire next_host_run = ((next_state == PMOC_SUPPLY_GOOD_STATUS_CHECK) ||
        (next_state == PMOC_NORMAL)) && !hw_long;
    wire next_standby = (next_state == PMOC_NORMAL) && (state == PMOC_NORMAL)
        && (mode_ctl[`PMOC_BIT_STANDBY] || standby_gpio_s);

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            mode_state <= PMOC_NO_POWER;
            host_reset_output <= 1'b0;
            sequencing_enable <= 1'b0;
            supplies_on <= 1'b0;
            backup_clock_regulator_on <= 1'b0;
            restore_defaults <= 1'b0;
            buck_a_standby <= 1'b0;
            buck_b_standby <= 1'b0;
            buck_pfm <= 1'b0;
            boost_low_freq_osc <= 1'b0;
        end
        else
        begin
            mode_state <= next_state;
            host_reset_output <= next_host_run; // R9 R17
            sequencing_enable <= (next_state == PMOC_SEQUENCING); // R10 R12
            supplies_on <= next_on; // R10
            backup_clock_regulator_on <= (next_state != PMOC_NO_POWER) &&
                backup_clock_en; // R11
            restore_defaults <= entering_sleep; // R9 R12
            buck_a_standby <= next_standby; // R16 R25
            buck_b_standby <= next_standby; // R16
            buck_pfm <= next_standby; // R16
            boost_low_freq_osc <= next_mode_ctl[`PMOC_BIT_BOOST_OSC];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions.
    sequence s_sleep_entry;
        state != PMOC_SLEEP ##1 state == PMOC_SLEEP;
    endsequence

    sequence s_sleep_outputs;
        !host_reset_output && !supplies_on && restore_defaults;
    endsequence

    property p_pgchk_normal;
        @(posedge core_clk) disable iff (!rst_n)
        state == PMOC_SUPPLY_GOOD_STATUS_CHECK && !pg_level && !uvlo_s
        |=> state == PMOC_NORMAL;
    endproperty
    a_pgchk_normal: assert property (p_pgchk_normal) // R3
        else $error("supply-good check did not enter normal");

    property p_pgchk_sleep;
        @(posedge core_clk) disable iff (!rst_n)
        state == PMOC_SUPPLY_GOOD_STATUS_CHECK && pg_level && !uvlo_s
        |=> state == PMOC_SLEEP && !mode_ctl[`PMOC_BIT_DEFAULTS_N];
    endproperty
    a_pgchk_sleep: assert property (p_pgchk_sleep) // R22
        else $error("supply fault in check did not enter sleep");

    property p_env_sleep;
        @(posedge core_clk) disable iff (!rst_n)
        state == PMOC_NORMAL && env_fault && !uvlo_s
        |=> state == PMOC_SLEEP;
    endproperty
    a_env_sleep: assert property (p_env_sleep) // R4
        else $error("thermal or low voltage fault did not enter sleep");

    property p_pg_nopower;
        @(posedge core_clk) disable iff (!rst_n)
        state == PMOC_NORMAL && $changed(sts_s & ~fault_mask) && !env_fault
        |=> state == PMOC_NO_POWER;
    endproperty
    a_pg_nopower: assert property (p_pg_nopower) // R5
        else $error("unmasked supply toggle did not enter no power");

    property p_soft_reset;
        @(posedge core_clk) disable iff (!rst_n)
        state == PMOC_NORMAL && soft_rst && !env_fault && !pg_event
        && !uvlo_s |=> state == PMOC_RESET ##1 !soft_rst || $past(wr_mode);
    endproperty
    a_soft_reset: assert property (p_soft_reset) // R6
        else $error("software reset did not enter reset");

    property p_self_clear;
        @(posedge core_clk) disable iff (!rst_n)
        (soft_rst || soft_sleep) && !wr_mode |=> !soft_rst && !soft_sleep;
    endproperty
    a_self_clear: assert property (p_self_clear) // R8
        else $error("request bit did not clear itself");

    property p_sleep_outputs;
        @(posedge core_clk) disable iff (!rst_n)
        s_sleep_entry |-> s_sleep_outputs ##1 !restore_defaults;
    endproperty
    a_sleep_outputs: assert property (p_sleep_outputs) // R9
        else $error("sleep entry outputs wrong");

    property p_thermal_hold;
        @(posedge core_clk) disable iff (!rst_n)
        state == PMOC_SLEEP && sleep_thermal && !uvlo_s
        |=> state == PMOC_SLEEP;
    endproperty
    a_thermal_hold: assert property (p_thermal_hold) // R13
        else $error("thermal sleep left without undervoltage");

    property p_hw_long;
        @(posedge core_clk) disable iff (!rst_n)
        !hw_s [*2] ##0 deglitch_cnt == deglitch_max
        |=> !host_reset_output;
    endproperty
    a_hw_long: assert property (p_hw_long) // R17
        else $error("host reset not driven low after deglitch");

    property p_hw_rise;
        @(posedge core_clk) disable iff (!rst_n)
        state == PMOC_NORMAL && !hw_s && !env_fault && !pg_event
        && !soft_rst && !soft_sleep && !uvlo_s |=> state == PMOC_NORMAL;
    endproperty
    a_hw_rise: assert property (p_hw_rise) // R18
        else $error("reset began while hardware reset held low");

    property p_standby;
        @(posedge core_clk) disable iff (!rst_n)
        state == PMOC_NORMAL && next_state == PMOC_NORMAL
        && mode_ctl[`PMOC_BIT_STANDBY] |=> buck_a_standby && buck_pfm;
    endproperty
    a_standby: assert property (p_standby) // R16
        else $error("standby request not applied to bucks");
endmodule

// ---- testbench/pmoc_host_model.sv ----
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////
module pmoc_host_model (
    // Clock.
    input wire logic core_clk,
    // Register port towards the device.
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // Host reset from the device.
    input wire logic host_reset_output
);
    initial
    begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end

    // Released lines carry the inverse so a stale value never matches.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge core_clk);
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge core_clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge core_clk);
        reg_rd = 1'b0;
        reg_addr = ~a;
        @(negedge core_clk);
        d = reg_rdata;
    endtask

    // The host marks its registers initialised once out of host reset.
    task automatic mark_loaded(input logic [7:0] mode);
        wait (host_reset_output === 1'b1);
        wr(8'h08, mode | 8'h02);
    endtask
endmodule

// ---- testbench/pmoc_mode_control_bench.sv ----
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////
module pmoc_mode_control_bench
    import pmoc_pkg::*;
;
    localparam int DG = 20;
    logic core_clk, rst_n, reg_wr, reg_rd, hw_reset_input, thermal_fault;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, supply_good_status;
    logic system_voltage_low, uvlo_detect, battery_present, standby_gpio;
    logic input_power_present, reset_timer_expired, sequence_done;
    logic backup_clock_en, host_reset_output, sequencing_enable, supplies_on;
    logic backup_clock_regulator_on, restore_defaults, buck_a_standby;
    logic buck_b_standby, buck_pfm, boost_low_freq_osc;
    pmoc_state_t mode_state;
    int n_restore = 0;
    int n_reset = 0;
    int miscompares = 0;
    int n_tests = 0;

    pmoc_mode_control #(.DEGLITCH_CYCLES(DG)) i_dut (.core_clk, .rst_n,
        .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .hw_reset_input,
        .thermal_fault, .system_voltage_low, .uvlo_detect, .battery_present,
        .input_power_present, .standby_gpio, .reset_timer_expired,
        .sequence_done, .supply_good_status, .backup_clock_en,
        .host_reset_output, .sequencing_enable, .supplies_on,
        .backup_clock_regulator_on, .restore_defaults, .buck_a_standby,
        .buck_b_standby, .buck_pfm, .boost_low_freq_osc, .mode_state);

    pmoc_host_model i_host (.core_clk, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .host_reset_output);

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    always @(posedge core_clk)
    begin
        if (restore_defaults === 1'b1)
            n_restore++;
        if (mode_state === PMOC_RESET)
            n_reset++;
    end

    task automatic chk(input string nm, input logic [7:0] seen,
                       input logic [7:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    task automatic wait_st(input pmoc_state_t s, input int lim);
        int k;
        k = 0;
        while (mode_state !== s && k < lim)
        begin
            @(negedge core_clk);
            k++;
        end
        chk("mode_state", 8'(mode_state), 8'(s));
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        i_host.rd(a, d);
        chk("register", d, exp);
    endtask

    task automatic stop_test;
        if (miscompares == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial
    begin
        #200000;
        miscompares++;
        stop_test();
    end

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        int r0;
        {rst_n, hw_reset_input, thermal_fault, system_voltage_low} = 4'h4;
        {uvlo_detect, battery_present, input_power_present} = 3'h3;
        {standby_gpio, reset_timer_expired, sequence_done} = 3'h3;
        supply_good_status = 8'h00;
        backup_clock_en = 1'b1;
        cyc(10);
        chk("mode_state", 8'(mode_state), 8'h00);
        rst_n = 1'b1;
        wait_st(PMOC_NORMAL, 60);
        chk("host_reset", 8'({host_reset_output, supplies_on}), 8'h03);
        rd_chk(8'h07, 8'hFF);
        rd_chk(8'h08, 8'h00);
        i_host.mark_loaded(8'h00);
        i_host.wr(8'h07, 8'hFE);
        rd_chk(8'h08, 8'h02);
        rd_chk(8'h30, 8'h00);
        i_host.wr(8'h02, 8'hFF);
        rd_chk(8'h02, 8'h00);
        // A masked supply out of regulation shows in status only.
        supply_good_status = 8'h02;
        cyc(10);
        chk("mode_state", 8'(mode_state), 8'h05);
        rd_chk(8'h02, 8'h02);
        supply_good_status = 8'h00;
        i_host.wr(8'h08, 8'h8A);
        cyc(4);
        chk("standby", 8'({buck_a_standby, buck_b_standby, buck_pfm,
            boost_low_freq_osc}), 8'h0F);
        i_host.wr(8'h08, 8'h02);
        standby_gpio = 1'b1;
        cyc(6);
        chk("standby", 8'({buck_a_standby, buck_b_standby, buck_pfm,
            boost_low_freq_osc}), 8'h0E);
        standby_gpio = 1'b0;
        cyc(6);
        chk("standby", 8'({buck_a_standby, buck_pfm}), 8'h00);
        i_host.wr(8'h08, 8'h03);
        wait_st(PMOC_RESET, 6);
        wait_st(PMOC_NORMAL, 20);
        rd_chk(8'h08, 8'h02);
        rd_chk(8'h07, 8'hFE);
        hw_reset_input = 1'b0;
        cyc(DG + 6);
        chk("host_reset", 8'(host_reset_output), 8'h00);
        chk("mode_state", 8'(mode_state), 8'h05);
        hw_reset_input = 1'b1;
        wait_st(PMOC_RESET, 6);
        wait_st(PMOC_NORMAL, 20);
        // Two short lows must not add up to one long low.
        r0 = n_reset;
        hw_reset_input = 1'b0;
        cyc(12);
        hw_reset_input = 1'b1;
        cyc(3);
        hw_reset_input = 1'b0;
        cyc(12);
        chk("host_reset", 8'(host_reset_output), 8'h01);
        hw_reset_input = 1'b1;
        cyc(8);
        chk("mode_state", 8'(mode_state), 8'h05);
        chk("reset_count", 8'(n_reset - r0), 8'h00);
        rd_chk(8'h08, 8'h02);
        input_power_present = 1'b0;
        cyc(4);
        r0 = n_restore;
        i_host.wr(8'h08, 8'h42);
        wait_st(PMOC_SLEEP, 6);
        cyc(2);
        chk("sleep_outputs", 8'({host_reset_output, supplies_on,
            sequencing_enable}), 8'h00);
        chk("restore_count", 8'(n_restore - r0), 8'h01);
        backup_clock_en = 1'b0;
        cyc(2);
        chk("backup", 8'(backup_clock_regulator_on), 8'h00);
        backup_clock_en = 1'b1;
        cyc(2);
        chk("backup", 8'(backup_clock_regulator_on), 8'h01);
        rd_chk(8'h08, 8'h02);
        input_power_present = 1'b1;
        wait_st(PMOC_ENABLE, 8);
        wait_st(PMOC_NORMAL, 30);
        system_voltage_low = 1'b1;
        wait_st(PMOC_SLEEP, 6);
        system_voltage_low = 1'b0;
        cyc(10);
        chk("mode_state", 8'(mode_state), 8'h06);
        input_power_present = 1'b0;
        cyc(5);
        input_power_present = 1'b1;
        wait_st(PMOC_ENABLE, 8);
        wait_st(PMOC_NORMAL, 30);
        thermal_fault = 1'b1;
        wait_st(PMOC_SLEEP, 6);
        thermal_fault = 1'b0;
        input_power_present = 1'b0;
        cyc(5);
        input_power_present = 1'b1;
        cyc(10);
        chk("mode_state", 8'(mode_state), 8'h06);
        uvlo_detect = 1'b1;
        wait_st(PMOC_NO_POWER, 6);
        rd_chk(8'h08, 8'h00);
        rd_chk(8'h07, 8'hFF);
        uvlo_detect = 1'b0;
        wait_st(PMOC_NORMAL, 60);
        i_host.mark_loaded(8'h00);
        i_host.wr(8'h07, 8'hFE);
        supply_good_status = 8'h01;
        wait_st(PMOC_NO_POWER, 6);
        supply_good_status = 8'h00;
        rd_chk(8'h08, 8'h00);
        wait_st(PMOC_NORMAL, 60);
        // Fault raised while RESET waits for its timer.
        reset_timer_expired = 1'b0;
        i_host.wr(8'h07, 8'hFE);
        i_host.wr(8'h08, 8'h01);
        wait_st(PMOC_RESET, 6);
        supply_good_status = 8'h01;
        cyc(6);
        chk("mode_state", 8'(mode_state), 8'h03);
        reset_timer_expired = 1'b1;
        wait_st(PMOC_SLEEP, 10);
        stop_test();
    end
endmodule
